/* src/multi_function_led_select.sv */
// Function
// [RULE1] strap sets polarity default: pull-up gives low
// [RULE2] polarity bit 0 active low, 1 high
// [RULE3] codes 0-3: link, activity, tx, rx
// [RULE4] codes 4-7: collision, speed100, speed10, duplex
// [RULE5] codes 8-11: linkblink, stretch, 100FD, LPI
// [RULE6] codes 12-14: MII error, link lost, PRBS
// [RULE7] link lost latches until control reg read
// [RULE8] PRBS error latches until self-test cleared
// [RULE9] route 00 to collision, 11 to first pin
// [RULE10] software clears PRBS by writing bit 15
// [RULE11] select, then invert, then route, clocked
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "multi_function_led_select_params.svh"

module multi_function_led_select #(
	parameter int BLINK_CYC   = `BLINK_CYC,
	parameter int STRETCH_CYC = `STRETCH_CYC
) (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst,
	// polarity strap pin
	input  wire logic                                strapPin,
	// PHY status
	input  wire multi_function_led_select_pkg::phy_status_t status,
	// Avalon-MM slave
	input  wire logic [9:0]                          address,
	input  wire logic                                read,
	input  wire logic                                write,
	input  wire logic [31:0]                         writedata,
	output logic      [31:0]                         readdata,
	output logic                                     waitrequest,
	// indicator pins
	output multi_function_led_select_pkg::pins_t     pins
);
	import multi_function_led_select_pkg::*;

	localparam int CW = 32;

	logic [15:0]  cfg_q, cfg_d;
	logic         strapDone_q, strapDone_d;
	logic [1:0]   strapSync_q;
	logic         linkPrev_q, linkLost_q, linkLost_d;
	logic         prbsLatch_q, prbsLatch_d;
	logic [CW-1:0] blinkCnt_q, blinkCnt_d;
	logic         blinkPh_q, blinkPh_d;
	logic [CW-1:0] strCnt_q, strCnt_d;
	logic         ack_q, ack_d;
	logic [31:0]  rdata_q, rdata_d;
	pins_t        pins_q, pins_d;
	logic         rawSrc, polSrc;
	logic [7:0]   idx;
	logic         busReq;

	assign idx         = address[9:2];
	assign busReq      = read | write;
	// one wait cycle per access: answer on the second edge
	assign waitrequest = busReq & ~ack_q;
	assign readdata    = rdata_q;
	assign pins        = pins_q;

	// strap synchroniser, kept out of reset so it already holds the
	// strap level when reset lets go and the default is loaded
	always_ff @(posedge clk) begin
		strapSync_q <= {strapSync_q[0], strapPin};
	end

	// register file, sticky flags and bus answer
	always_comb begin
		cfg_d       = cfg_q;
		strapDone_d = 1'b1;
		linkLost_d  = linkLost_q;
		prbsLatch_d = prbsLatch_q;
		ack_d       = busReq & ~ack_q;
		rdata_d     = rdata_q;
		if (!strapDone_q) begin
			cfg_d[`POL_BIT] = ~strapSync_q[1]; // see [RULE1]
		end
		// writes land on the edge that sees waitrequest low
		if (busReq && ack_q && write) begin
			if (idx == `IND_CFG_IDX) begin
				cfg_d = writedata[15:0];
			end else if (idx == `STEST_STAT_IDX &&
					writedata[`STEST_CLR_BIT]) begin
				prbsLatch_d = 1'b0; // see [RULE10]
			end
		end
		if (busReq && !ack_q && read) begin
			if (idx == `IND_CFG_IDX) begin
				rdata_d = {16'h0000, cfg_q};
			end else if (idx == `STEST_STAT_IDX) begin
				rdata_d = {31'h0, prbsLatch_q};
			end else if (idx == `BASIC_CTRL_IDX) begin
				rdata_d = {31'h0, linkLost_q};
				linkLost_d = 1'b0; // see [RULE7]
			end else begin
				rdata_d = 32'h0000_0000;
			end
		end
		// events win over clears
		if (linkPrev_q && !status.linkUp) begin
			linkLost_d = 1'b1; // see [RULE7]
		end
		if (status.prbsError) begin
			prbsLatch_d = 1'b1; // see [RULE8]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q       <= `IND_CFG_RST;
			strapDone_q <= 1'b0;
			linkPrev_q  <= 1'b0;
			linkLost_q  <= 1'b0;
			prbsLatch_q <= 1'b0;
			ack_q       <= 1'b0;
			rdata_q     <= 32'h0000_0000;
		end else begin
			cfg_q       <= cfg_d;
			strapDone_q <= strapDone_d;
			linkPrev_q  <= status.linkUp;
			linkLost_q  <= linkLost_d;
			prbsLatch_q <= prbsLatch_d;
			ack_q       <= ack_d;
			rdata_q     <= rdata_d;
		end
	end

	// blink phase and activity stretch counters
	always_comb begin
		blinkCnt_d = blinkCnt_q + CW'(1);
		blinkPh_d  = blinkPh_q;
		if (blinkCnt_q >= CW'(BLINK_CYC - 1)) begin
			blinkCnt_d = '0;
			blinkPh_d  = ~blinkPh_q;
		end
		strCnt_d = (strCnt_q != '0) ? strCnt_q - CW'(1) : '0;
		if (status.txAct || status.rxAct) begin
			strCnt_d = CW'(STRETCH_CYC);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			blinkCnt_q <= '0;
			blinkPh_q  <= 1'b0;
			strCnt_q   <= '0;
		end else begin
			blinkCnt_q <= blinkCnt_d;
			blinkPh_q  <= blinkPh_d;
			strCnt_q   <= strCnt_d;
		end
	end

	// source select, polarity, then routing
	always_comb begin
		case (source_t'(cfg_q[`SRC_HI:`SRC_LO]))
			SRC_LINK:      rawSrc = status.linkUp; // see [RULE3]
			SRC_ACT:       rawSrc = status.txAct | status.rxAct;
			SRC_TX:        rawSrc = status.txAct;
			SRC_RX:        rawSrc = status.rxAct;
			SRC_COL:       rawSrc = status.collision; // see [RULE4]
			SRC_SPD100:    rawSrc = status.linkUp & status.speed100;
			SRC_SPD10:     rawSrc = status.linkUp & ~status.speed100;
			SRC_FDX:       rawSrc = status.fullDuplex;
			SRC_LINKBLINK: rawSrc = status.linkUp & // see [RULE5]
					~((status.txAct | status.rxAct) & blinkPh_q);
			SRC_STRETCH:   rawSrc = (strCnt_q != '0);
			SRC_LINK100FD: rawSrc = status.linkUp & status.speed100 &
					status.fullDuplex;
			SRC_LPI:       rawSrc = status.lpiActive;
			SRC_MIIERR:    rawSrc = status.miiError; // see [RULE6]
			SRC_LINKLOST:  rawSrc = linkLost_q; // see [RULE7]
			SRC_PRBS:      rawSrc = prbsLatch_q; // see [RULE8]
			default:       rawSrc = 1'b0;
		endcase
		// bit 0 drives low when lit
		polSrc = cfg_q[`POL_BIT] ? rawSrc : ~rawSrc; // see [RULE2]
		pins_d.colPin            = ~cfg_q[`POL_BIT];
		pins_d.firstIndicatorPin = ~cfg_q[`POL_BIT];
		if (cfg_q[`ROUTE_HI:`ROUTE_LO] == `ROUTE_COL) begin
			pins_d.colPin = polSrc; // see [RULE9]
		end else if (cfg_q[`ROUTE_HI:`ROUTE_LO] == `ROUTE_FIRST) begin
			pins_d.firstIndicatorPin = polSrc; // see [RULE9]
		end
	end

	// registered output stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins_q <= '0;
		end else begin
			pins_q <= pins_d; // see [RULE11]
		end
	end

	// assertions
	property p_strap;
		@(posedge clk) disable iff (rst)
		$rose(strapDone_q) |-> cfg_q[`POL_BIT] == ~$past(strapSync_q[1]);
	endproperty
	a_strap: assert property (p_strap) // see [RULE1]
		else $error("polarity default not from strap");

	property p_lost;
		@(posedge clk) disable iff (rst)
		($fell(status.linkUp) && strapDone_q) |=> linkLost_q;
	endproperty
	a_lost: assert property (p_lost) // see [RULE7]
		else $error("link lost not latched");

	property p_prbs;
		@(posedge clk) disable iff (rst)
		status.prbsError |=> prbsLatch_q;
	endproperty
	a_prbs: assert property (p_prbs) // see [RULE8]
		else $error("prbs error not latched");

	property p_route;
		@(posedge clk) disable iff (rst)
		(cfg_q[1:0] == 2'h0 && $stable(cfg_q)) |=>
			pins_q.colPin == $past(polSrc);
	endproperty
	a_route: assert property (p_route) // see [RULE9]
		else $error("collision pin not routed");

	property p_pol;
		@(posedge clk) disable iff (rst)
		(cfg_q[1:0] == 2'h3) |=> pins_q.firstIndicatorPin ==
			($past(cfg_q[9]) ? $past(rawSrc) : ~$past(rawSrc));
	endproperty
	a_pol: assert property (p_pol) // see [RULE2]
		else $error("polarity wrong on first pin");

	property p_link;
		@(posedge clk) disable iff (rst)
		(cfg_q[6:3] == 4'h0) |-> rawSrc == status.linkUp;
	endproperty
	a_link: assert property (p_link) // see [RULE3]
		else $error("link source wrong");

	property p_col;
		@(posedge clk) disable iff (rst)
		(cfg_q[6:3] == 4'h4) |-> rawSrc == status.collision;
	endproperty
	a_col: assert property (p_col) // see [RULE4]
		else $error("collision source wrong");

	property p_wait;
		@(posedge clk) disable iff (rst)
		$rose(busReq) |-> waitrequest ##1 !waitrequest;
	endproperty
	a_wait: assert property (p_wait) // see the Avalon-MM port decided for this implementation
		else $error("bus answer not in one wait cycle");

endmodule : multi_function_led_select

/* src/multi_function_led_select_params.svh */
`ifndef MULTI_FUNCTION_LED_SELECT_PARAMS_SVH
`define MULTI_FUNCTION_LED_SELECT_PARAMS_SVH

// register indices, byte address is four times the index
`define IND_CFG_IDX      8'h25
`define BASIC_CTRL_IDX   8'h01
`define STEST_STAT_IDX   8'h1B
// indicator_config field positions
`define POL_BIT          9
`define SRC_HI           6
`define SRC_LO           3
`define ROUTE_HI         1
`define ROUTE_LO         0
`define STEST_CLR_BIT    15
// reset value of the config register, polarity bit filled from strap
`define IND_CFG_RST      16'h0000
`define ROUTE_COL        2'h0
`define ROUTE_FIRST      2'h3
// blink half period and activity stretch time
`define BLINK_NS         50000000
`define STRETCH_NS       50000000
`define CLK_NS           50
`define BLINK_CYC        (`BLINK_NS / `CLK_NS)
`define STRETCH_CYC      (`STRETCH_NS / `CLK_NS)

`endif

/* src/multi_function_led_select_pkg.sv */
package multi_function_led_select_pkg;

	// indicator source codes
	typedef enum logic [3:0] {
		SRC_LINK      = 4'h0,
		SRC_ACT       = 4'h1,
		SRC_TX        = 4'h2,
		SRC_RX        = 4'h3,
		SRC_COL       = 4'h4,
		SRC_SPD100    = 4'h5,
		SRC_SPD10     = 4'h6,
		SRC_FDX       = 4'h7,
		SRC_LINKBLINK = 4'h8,
		SRC_STRETCH   = 4'h9,
		SRC_LINK100FD = 4'hA,
		SRC_LPI       = 4'hB,
		SRC_MIIERR    = 4'hC,
		SRC_LINKLOST  = 4'hD,
		SRC_PRBS      = 4'hE,
		SRC_RSVD      = 4'hF
	} source_t;

	// PHY status inputs, all on the PHY clock
	typedef struct packed {
		logic linkUp;
		logic txAct;
		logic rxAct;
		logic collision;
		logic speed100;
		logic fullDuplex;
		logic lpiActive;
		logic miiError;
		logic prbsError;
	} phy_status_t;

	// indicator output pins
	typedef struct packed {
		logic colPin;
		logic firstIndicatorPin;
	} pins_t;

endpackage : multi_function_led_select_pkg

/* tb/indicator_led_model.sv */
`timescale 1ns/1ps
module indicator_led_model (
	// strap choice and indicator pin
	input  wire logic pullUp,
	input  wire logic pin,
	// strap level at the device, lamp state
	output logic      strapLevel,
	output logic      glow
);
	// resistor holds the strap level, lamp follows the pin
	assign strapLevel = pullUp;
	assign glow       = pin;
endmodule : indicator_led_model

/* tb/multi_function_led_select_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module multi_function_led_select_tb;
	import multi_function_led_select_pkg::*;
	logic        clk, rst, pullUp, strapPin, read, write, waitrequest;
	logic        pol, s, ec, ef;
	logic [1:0]  rt;
	logic [9:0]  address;
	logic [31:0] writedata, readdata, e;
	logic [31:0] expQ[$];
	phy_status_t status, st;
	pins_t       pins;
	int          err_count, checks;

	multi_function_led_select #(.BLINK_CYC(4), .STRETCH_CYC(4)) i_dut (
		.clk(clk), .rst(rst), .strapPin(strapPin), .status(status),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .pins(pins));
	indicator_led_model i_led (.pullUp(pullUp),
		.pin(pins.firstIndicatorPin), .strapLevel(strapPin), .glow());

	// free-running clock
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge clk);
		write <= wr;
		read <= ~wr;
		address <= a;
		writedata <= d;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		write <= 0;
		read <= 0;
	endtask : bus

	task automatic rd(input logic [9:0] a, input logic [31:0] x);
		expQ.push_back(x);
		bus(1'b0, a, 32'h0);
	endtask : rd

	// read results are compared as they appear
	always @(posedge clk) begin
		if (read && !waitrequest && expQ.size() > 0) begin
			e = expQ.pop_front();
			`CHK("readdata", e, readdata)
		end
	end

	// source level expected for each select code
	function automatic logic srcVal(input logic [3:0] c, input phy_status_t t);
		case (c)
			4'h0, 4'h8: return t.linkUp;
			4'h1: return t.txAct | t.rxAct;
			4'h2: return t.txAct;
			4'h3: return t.rxAct;
			4'h4: return t.collision;
			4'h5: return t.linkUp & t.speed100;
			4'h6: return t.linkUp & ~t.speed100;
			4'h7: return t.fullDuplex;
			4'hA: return t.linkUp & t.speed100 & t.fullDuplex;
			4'hB: return t.lpiActive;
			4'hC: return t.miiError;
			default: return 1'b0;
		endcase
	endfunction : srcVal

	task automatic end_sim;
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_sim();
	end

	// main sequence
	initial begin
		void'($urandom(27918));
		rst = 1;
		pullUp = 0;
		read = 0;
		write = 0;
		address = 0;
		writedata = 0;
		status = '0;
		st = '0;
		repeat (5) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		rd(10'h094, 32'h0000_0200);
		pullUp <= 1;
		rst <= 1;
		repeat (5) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		rd(10'h094, 32'h0000_0000);
		for (int k = 0; k < 64; k++) begin
			pol = 1'($urandom_range(1));
			rt = k[1:0];
			bus(1'b1, 10'h094, {22'h0, pol, 2'h0, 4'(k >> 2), 1'b0, rt});
			st = phy_status_t'(9'($urandom));
			st.linkUp = 1;
			st.prbsError = 0;
			if (k >= 32 && k < 40) {st.txAct, st.rxAct} = 2'h0;
			status <= st;
			repeat (6) @(posedge clk);
			s = srcVal(4'(k >> 2), st);
			ec = (rt == 2'h0) ? ~(pol ^ s) : ~pol;
			ef = (rt == 2'h3) ? ~(pol ^ s) : ~pol;
			`CHK("colPin", ec, pins.colPin)
			`CHK("firstPin", ef, pins.firstIndicatorPin)
		end
		// one activity pulse is stretched for a few cycles
		bus(1'b1, 10'h094, 32'h0000_024B);
		st = '0;
		status <= st;
		repeat (6) @(posedge clk);
		st.txAct = 1;
		status <= st;
		@(posedge clk);
		status <= '0;
		repeat (2) @(posedge clk);
		`CHK("stretchOn", 1'b1, pins.firstIndicatorPin)
		repeat (5) @(posedge clk);
		`CHK("stretchOff", 1'b0, pins.firstIndicatorPin)
		bus(1'b1, 10'h094, 32'h0000_026B);
		st = '0;
		status <= st;
		repeat (3) @(posedge clk);
		st.linkUp = 1;
		status <= st;
		repeat (3) @(posedge clk);
		status <= '0;
		repeat (3) @(posedge clk);
		status <= st;
		repeat (3) @(posedge clk);
		`CHK("linkLost", 1'b1, pins.firstIndicatorPin)
		rd(10'h004, 32'h0000_0001);
		repeat (3) @(posedge clk);
		`CHK("lostClear", 1'b0, pins.firstIndicatorPin)
		bus(1'b1, 10'h094, 32'h0000_0273);
		st.prbsError = 1;
		status <= st;
		@(posedge clk);
		st.prbsError = 0;
		status <= st;
		repeat (3) @(posedge clk);
		`CHK("prbs", 1'b1, pins.firstIndicatorPin)
		rd(10'h06C, 32'h0000_0001);
		bus(1'b1, 10'h06C, 32'h0000_8000);
		repeat (3) @(posedge clk);
		`CHK("prbsClear", 1'b0, pins.firstIndicatorPin)
		rd(10'h3FC, 32'h0000_0000);
		bus(1'b1, 10'h3FC, 32'h0000_FFFF);
		rd(10'h094, 32'h0000_0273);
		@(posedge clk);
		end_sim();
	end
endmodule : multi_function_led_select_tb
